// >>> pkg/frc_pkg.sv
// Shared constants and types of the free-running counter block
package frc_pkg;
  // Register byte offsets on the AXI4-Lite bus
  localparam logic [7:0] OFS_COUNT_HIGH = 8'h00;
  localparam logic [7:0] OFS_COUNT_LOW = 8'h04;
  localparam logic [7:0] OFS_ALT_HIGH = 8'h08;
  localparam logic [7:0] OFS_ALT_LOW = 8'h0C;
  localparam logic [7:0] OFS_CTRL_ONE = 8'h10;
  localparam logic [7:0] OFS_CTRL_TWO = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  // Field positions
  localparam int BIT_IRQ_EN = 7;
  localparam int BIT_EDGE_SEL = 2;
  localparam int BIT_WRAP_FLAG = 5;
  // Counter values
  localparam logic [15:0] RELOAD_COUNT = 16'hFFFC;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;
  localparam logic [15:0] COUNT_ONE = 16'h0001;
  localparam logic [2:0] PRESC_ONE = 3'h1;
  localparam logic [2:0] PRESC_ZERO = 3'h0;
  localparam logic [2:0] PRESC_DIV4_END = 3'h3;
  localparam logic [2:0] PRESC_DIV8_END = 3'h7;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Count rate codes
  typedef enum logic [1:0] {
    RATE_DIV2 = 2'h0,
    RATE_DIV4 = 2'h1,
    RATE_DIV8 = 2'h2,
    RATE_EXT = 2'h3
  } frc_rate_t;
  // Control bits held by software
  typedef struct packed {
    logic wrap_irq_enable;
    logic ext_edge_select;
    frc_rate_t rate_select;
  } frc_ctrl_t;
  localparam frc_ctrl_t CTRL_RESET = '{1'b0, 1'b0, RATE_DIV2};
endpackage

// >>> hdl/frc_top.sv
// Sixteen-bit free-running counter with AXI4-Lite register access
`timescale 1ns/100ps
module frc_top
  import frc_pkg::*;
#(
  parameter bit EXT_PIN_BONDED = 1'b1
) (
  input wire logic CLK_I,
  input wire logic RSTN_I,
  input wire logic [7:0] AWADDR_I,
  input wire logic AWVALID_I,
  output logic AWREADY_O,
  input wire logic [31:0] WDATA_I,
  input wire logic [3:0] WSTRB_I,
  input wire logic WVALID_I,
  output logic WREADY_O,
  output logic [1:0] BRESP_O,
  output logic BVALID_O,
  input wire logic BREADY_I,
  input wire logic [7:0] ARADDR_I,
  input wire logic ARVALID_I,
  output logic ARREADY_O,
  output logic [31:0] RDATA_O,
  output logic [1:0] RRESP_O,
  output logic RVALID_O,
  input wire logic RREADY_I,
  input wire logic EXT_COUNT_PIN_I,
  input wire logic CPU_IRQ_MASK_I,
  input wire logic WAIT_MODE_I,
  input wire logic HALT_MODE_I,
  output logic WRAP_IRQ_O,
  output logic [15:0] COUNT_O
);
  import frc_pkg::*;

  // Counter, prescaler and read buffer state
  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  logic [2:0] presc_reg;
  logic [2:0] presc_next;
  logic [7:0] low_buf_reg;
  logic lock_reg;
  logic lock_next;
  logic wrap_flag_reg;
  logic wrap_flag_next;
  logic clr_arm_reg;
  logic clr_arm_next;
  frc_ctrl_t ctrl_reg;
  frc_ctrl_t ctrl_next;
  // External pin synchroniser stages
  logic ext_s1_reg;
  logic ext_s2_reg;
  logic ext_s3_reg;
  // Bus channel state
  logic aw_full_reg;
  logic w_full_reg;
  logic [7:0] waddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic awready_reg;
  logic wready_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic arready_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic irq_reg;

  // Channel handshakes
  wire aw_take = AWVALID_I & awready_reg;
  wire w_take = WVALID_I & wready_reg;
  wire ar_take = ARVALID_I & arready_reg;
  wire aw_have = aw_full_reg | aw_take;
  wire w_have = w_full_reg | w_take;
  wire do_write = aw_have & w_have;
  wire [7:0] wa = aw_full_reg ? waddr_reg : AWADDR_I;
  wire [31:0] wd = w_full_reg ? wdata_reg : WDATA_I;
  wire [3:0] ws = w_full_reg ? wstrb_reg : WSTRB_I;
  wire aw_full_next = aw_have & ~do_write;
  wire w_full_next = w_have & ~do_write;
  wire bvalid_next = do_write | (bvalid_reg & ~BREADY_I);
  wire rvalid_next = ar_take | (rvalid_reg & ~RREADY_I);

  // Address match helper, used for both channels
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  // Write-side decode
  wire w_low_main = do_write & hit(wa, OFS_COUNT_LOW);
  wire w_low_alt = do_write & hit(wa, OFS_ALT_LOW);
  wire w_ctrl1 = do_write & hit(wa, OFS_CTRL_ONE) & ws[0];
  wire w_ctrl2 = do_write & hit(wa, OFS_CTRL_TWO) & ws[0];
  wire w_ok = hit(wa, OFS_COUNT_HIGH) | hit(wa, OFS_COUNT_LOW) | hit(wa, OFS_ALT_HIGH)
    | hit(wa, OFS_ALT_LOW) | hit(wa, OFS_CTRL_ONE) | hit(wa, OFS_CTRL_TWO)
    | hit(wa, OFS_STATUS);
  // Read-side decode
  wire r_high = ar_take & (hit(ARADDR_I, OFS_COUNT_HIGH) | hit(ARADDR_I, OFS_ALT_HIGH));
  wire r_low_main = ar_take & hit(ARADDR_I, OFS_COUNT_LOW);
  wire r_low_alt = ar_take & hit(ARADDR_I, OFS_ALT_LOW);
  wire r_low = r_low_main | r_low_alt;
  wire r_status = ar_take & hit(ARADDR_I, OFS_STATUS);
  wire reload = w_low_main | w_low_alt;

  // Read data selection
  wire [7:0] low_view = lock_reg ? low_buf_reg : cnt_reg[7:0];
  wire [7:0] ctrl1_view = {ctrl_reg.wrap_irq_enable, 7'h00};
  wire [7:0] ctrl2_view = {5'h00, ctrl_reg.ext_edge_select, ctrl_reg.rate_select};
  wire [7:0] stat_view = {2'h0, wrap_flag_reg, 5'h00};
  wire [7:0] r_byte =
    (hit(ARADDR_I, OFS_COUNT_HIGH) | hit(ARADDR_I, OFS_ALT_HIGH)) ? cnt_reg[15:8] :
    (hit(ARADDR_I, OFS_COUNT_LOW) | hit(ARADDR_I, OFS_ALT_LOW)) ? low_view :
    hit(ARADDR_I, OFS_CTRL_ONE) ? ctrl1_view :
    hit(ARADDR_I, OFS_CTRL_TWO) ? ctrl2_view :
    hit(ARADDR_I, OFS_STATUS) ? stat_view : 8'h00;
  wire r_ok = hit(ARADDR_I, OFS_COUNT_HIGH) | hit(ARADDR_I, OFS_COUNT_LOW)
    | hit(ARADDR_I, OFS_ALT_HIGH) | hit(ARADDR_I, OFS_ALT_LOW)
    | hit(ARADDR_I, OFS_CTRL_ONE) | hit(ARADDR_I, OFS_CTRL_TWO)
    | hit(ARADDR_I, OFS_STATUS);

  // External source: unbonded pin reads high
  wire ext_pin = EXT_PIN_BONDED ? EXT_COUNT_PIN_I : 1'b1;
  wire ext_rise = ext_s2_reg & ~ext_s3_reg;
  wire ext_fall = ~ext_s2_reg & ext_s3_reg;
  wire ext_edge = ctrl_reg.ext_edge_select ? ext_rise : ext_fall;

  // Prescaler tick decode
  wire tick_div2 = presc_reg[0];
  wire tick_div4 = (presc_reg[1:0] == PRESC_DIV4_END[1:0]);
  wire tick_div8 = (presc_reg == PRESC_DIV8_END);
  logic tick;
  always_comb begin
    unique case (ctrl_reg.rate_select)
      RATE_DIV2: tick = tick_div2;
      RATE_DIV4: tick = tick_div4;
      RATE_DIV8: tick = tick_div8;
      RATE_EXT: tick = ext_edge;
    endcase
  end
  // Halt freezes; wait mode has no effect here
  wire run = ~HALT_MODE_I;
  wire advance = run & tick & ~reload;
  wire wrap = advance & (cnt_reg == COUNT_MAX);

  // Counter and prescaler next values
  always_comb begin
    cnt_next = cnt_reg;
    presc_next = presc_reg;
    if (reload) begin
      cnt_next = RELOAD_COUNT;
      presc_next = PRESC_ZERO;
    end else if (run) begin
      presc_next = presc_reg + PRESC_ONE;
      if (tick) begin
        cnt_next = cnt_reg + COUNT_ONE;
      end
    end
  end

  // Read buffer lock: high read locks, low read releases
  always_comb begin
    lock_next = lock_reg;
    if (r_high) begin
      lock_next = 1'b1;
    end else if (r_low) begin
      lock_next = 1'b0;
    end
  end

  // Wrap flag with two-step clear; a new wrap wins
  always_comb begin
    wrap_flag_next = wrap_flag_reg;
    clr_arm_next = clr_arm_reg;
    if (r_status & wrap_flag_reg) begin
      clr_arm_next = 1'b1;
    end
    if (clr_arm_reg & (r_low_main | w_low_main)) begin
      wrap_flag_next = 1'b0;
      clr_arm_next = 1'b0;
    end
    if (wrap) begin
      wrap_flag_next = 1'b1;
    end
  end

  // Control register updates
  always_comb begin
    ctrl_next = ctrl_reg;
    if (w_ctrl1) begin
      ctrl_next.wrap_irq_enable = wd[BIT_IRQ_EN];
    end
    if (w_ctrl2) begin
      ctrl_next.ext_edge_select = wd[BIT_EDGE_SEL];
      ctrl_next.rate_select = frc_rate_t'(wd[1:0]);
    end
  end

  // Timer state registers
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      cnt_reg <= RELOAD_COUNT;
      presc_reg <= PRESC_ZERO;
      lock_reg <= 1'b0;
      wrap_flag_reg <= 1'b0;
      clr_arm_reg <= 1'b0;
      ctrl_reg <= CTRL_RESET;
      irq_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      presc_reg <= presc_next;
      lock_reg <= lock_next;
      wrap_flag_reg <= wrap_flag_next;
      clr_arm_reg <= clr_arm_next;
      ctrl_reg <= ctrl_next;
      irq_reg <= wrap_flag_reg & ctrl_reg.wrap_irq_enable & ~CPU_IRQ_MASK_I;
    end
  end

  // Capture low byte on a high read, only while unlocked
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      low_buf_reg <= 8'h00;
    end else if (r_high & ~lock_reg) begin
      low_buf_reg <= cnt_reg[7:0];
    end
  end

  // Two-stage synchroniser plus edge history
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      ext_s1_reg <= 1'b1;
      ext_s2_reg <= 1'b1;
      ext_s3_reg <= 1'b1;
    end else begin
      ext_s1_reg <= ext_pin;
      ext_s2_reg <= ext_s1_reg;
      ext_s3_reg <= ext_s2_reg;
    end
  end

  // Write channels
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      waddr_reg <= 8'h00;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
    end else begin
      aw_full_reg <= aw_full_next;
      w_full_reg <= w_full_next;
      awready_reg <= ~aw_full_next & ~bvalid_next;
      wready_reg <= ~w_full_next & ~bvalid_next;
      bvalid_reg <= bvalid_next;
      if (aw_take) begin
        waddr_reg <= AWADDR_I;
      end
      if (w_take) begin
        wdata_reg <= WDATA_I;
        wstrb_reg <= WSTRB_I;
      end
      if (do_write) begin
        bresp_reg <= w_ok ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // Read channels
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= RESP_OKAY;
    end else begin
      arready_reg <= ~rvalid_next;
      rvalid_reg <= rvalid_next;
      if (ar_take) begin
        rdata_reg <= {24'h000000, r_byte};
        rresp_reg <= r_ok ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // Output drive
  assign AWREADY_O = awready_reg;
  assign WREADY_O = wready_reg;
  assign BVALID_O = bvalid_reg;
  assign BRESP_O = bresp_reg;
  assign ARREADY_O = arready_reg;
  assign RVALID_O = rvalid_reg;
  assign RDATA_O = rdata_reg;
  assign RRESP_O = rresp_reg;
  assign WRAP_IRQ_O = irq_reg;
  assign COUNT_O = cnt_reg;

  // Checks
  a_reload_forces: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    reload |=> cnt_reg == RELOAD_COUNT) else $error("Low byte write did not reload");
  a_reset_count: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    !$past(RSTN_I) |-> cnt_reg == RELOAD_COUNT) else $error("Wrong count after reset");
  a_count_step: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    advance |=> cnt_reg == $past(cnt_reg) + COUNT_ONE) else $error("Counter did not step");
  a_halt_holds: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    HALT_MODE_I && !reload |=> $stable(cnt_reg)) else $error("Counter moved in halt");
  a_div8_spacing: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    ctrl_reg.rate_select == RATE_DIV8 && !HALT_MODE_I && tick && !reload
    |=> !tick [*7]) else $error("Divide by eight ticks too often");
  a_wrap_flag_set: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    wrap |=> wrap_flag_reg && cnt_reg == 16'h0000) else $error("Wrap did not set flag");
  a_alt_keeps_flag: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    wrap_flag_reg && !(r_low_main || w_low_main) |=> wrap_flag_reg)
    else $error("Flag cleared without main low access");
  a_clear_pair: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    $fell(wrap_flag_reg) |-> $past(clr_arm_reg) && $past(r_low_main || w_low_main))
    else $error("Flag cleared out of sequence");
  a_irq_gate: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    WRAP_IRQ_O |-> $past(wrap_flag_reg && ctrl_reg.wrap_irq_enable && !CPU_IRQ_MASK_I))
    else $error("Interrupt raised while gated");
  a_buffer_frozen: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    lock_reg && !r_low |=> lock_reg && $stable(low_buf_reg)) else $error("Buffer moved");
  a_ext_edge_count: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    ctrl_reg.rate_select == RATE_EXT && !tick && !reload |=> $stable(cnt_reg))
    else $error("External mode counted without edge");
  // Wait mode must never slow or stop the count
  a_wait_runs: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    WAIT_MODE_I && !HALT_MODE_I && tick && !reload |=> cnt_reg == $past(cnt_reg) + COUNT_ONE)
    else $error("Counter stopped in wait mode");
  a_div2_spacing: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    ctrl_reg.rate_select == RATE_DIV2 && !HALT_MODE_I && tick && !reload |=> !tick)
    else $error("Divide by two ticks too often");
  a_div4_spacing: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    ctrl_reg.rate_select == RATE_DIV4 && !HALT_MODE_I && tick && !reload |=> !tick [*3])
    else $error("Divide by four ticks too often");
  // Read buffer behaviour seen from the bus
  a_buffer_capture: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    r_high && !lock_reg |=> lock_reg && low_buf_reg == $past(cnt_reg[7:0]))
    else $error("High read did not capture low byte");
  a_live_low: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    r_low && !lock_reg |=> RDATA_O[7:0] == $past(cnt_reg[7:0]))
    else $error("Unlocked low read not live");
  a_locked_low: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    r_low && lock_reg |=> !lock_reg && RDATA_O[7:0] == $past(low_buf_reg))
    else $error("Locked low read not from buffer");
  a_irq_pending: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    wrap_flag_reg && ctrl_reg.wrap_irq_enable && !CPU_IRQ_MASK_I |=> WRAP_IRQ_O)
    else $error("Pending interrupt not raised");
  // Rising mode tick must trail the pin edge by the synchroniser depth
  a_ext_sync: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    ctrl_reg.rate_select == RATE_EXT && ctrl_reg.ext_edge_select && tick
    |-> $past(ext_pin, 2) && !$past(ext_pin, 3)) else $error("Rising edge count out of step");
endmodule

// >>> bench/frc_ext_src.sv
// External count source standing in for the pin driver
`timescale 1ns/100ps
module frc_ext_src (
  input wire logic clk_i,
  output logic pin_o = 1'b0
);
  // Level holds between bursts; each toggle waits five clock edges
  task automatic toggles(input int n);
    repeat (n) begin
      repeat (5) @(posedge clk_i);
      pin_o <= ~pin_o;
    end
  endtask
endmodule

// >>> bench/frc_top_test.sv
// Self-checking bench for the free-running counter block
`timescale 1ns/100ps
module frc_top_test;
  import frc_pkg::*;
  // Bus, mode and reset drives
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] aw_addr = 8'h00;
  logic aw_vld = 1'b0;
  logic [31:0] w_data = 32'h0;
  logic w_vld = 1'b0;
  logic b_rdy = 1'b0;
  logic [7:0] ar_addr = 8'h00;
  logic ar_vld = 1'b0;
  logic r_rdy = 1'b0;
  logic mask = 1'b1;
  logic wait_m = 1'b0;
  logic halt = 1'b1;
  // Design outputs and source pin
  logic aw_rdy, w_rdy, b_vld, ar_rdy, r_vld, irq, pin;
  logic [1:0] b_resp, r_resp;
  logic [31:0] r_data;
  logic [15:0] count, c0;
  // Bookkeeping
  int err_total = 0;
  int total_checks = 0;
  int cyc = 0;
  // Clock, 8 ns period
  always #4 clk = ~clk;
  frc_ext_src i_src (.clk_i(clk), .pin_o(pin));
  frc_top i_dut (
    .CLK_I(clk), .RSTN_I(rstn), .AWADDR_I(aw_addr), .AWVALID_I(aw_vld),
    .AWREADY_O(aw_rdy), .WDATA_I(w_data), .WSTRB_I(4'hF), .WVALID_I(w_vld),
    .WREADY_O(w_rdy), .BRESP_O(b_resp), .BVALID_O(b_vld), .BREADY_I(b_rdy),
    .ARADDR_I(ar_addr), .ARVALID_I(ar_vld), .ARREADY_O(ar_rdy), .RDATA_O(r_data),
    .RRESP_O(r_resp), .RVALID_O(r_vld), .RREADY_I(r_rdy), .EXT_COUNT_PIN_I(pin),
    .CPU_IRQ_MASK_I(mask), .WAIT_MODE_I(wait_m), .HALT_MODE_I(halt),
    .WRAP_IRQ_O(irq), .COUNT_O(count)
  );
  // Verdict and end of run
  task automatic close_out;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Compare one value
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Write cycle: address and data offered together, response awaited
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic pa, pw;
    @(posedge clk);
    pa = 1'b1;
    pw = 1'b1;
    aw_addr <= a;
    w_data <= d;
    aw_vld <= 1'b1;
    w_vld <= 1'b1;
    b_rdy <= 1'b1;
    while (pa || pw) begin
      @(posedge clk);
      if (pa && aw_rdy === 1'b1) begin
        pa = 1'b0;
        aw_vld <= 1'b0;
      end
      if (pw && w_rdy === 1'b1) begin
        pw = 1'b0;
        w_vld <= 1'b0;
      end
    end
    while (b_vld !== 1'b1) @(posedge clk);
    r = b_resp;
    b_rdy <= 1'b0;
  endtask
  // Read cycle: address held until taken, data taken with rvalid
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    ar_addr <= a;
    ar_vld <= 1'b1;
    r_rdy <= 1'b1;
    do @(posedge clk); while (ar_rdy !== 1'b1);
    ar_vld <= 1'b0;
    while (r_vld !== 1'b1) @(posedge clk);
    d = r_data;
    r = r_resp;
    r_rdy <= 1'b0;
  endtask
  // Read and compare data byte and response
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk("rdata", {24'h0, e}, d);
    chk("rresp", {30'h0, er}, {30'h0, r});
  endtask
  // Write and compare response
  task automatic wrchk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic [1:0] r;
    wr(a, d, r);
    chk("bresp", {30'h0, er}, {30'h0, r});
  endtask
  // Let the counter run for a set number of edges, then freeze it
  task automatic run(input int n);
    halt <= 1'b0;
    repeat (n) @(posedge clk);
    halt <= 1'b1;
    @(posedge clk);
  endtask
  // Hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      close_out();
    end
  end
  // Main sequence
  initial begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    chk("count", 32'h0000FFFC, {16'h0, count});
    rdchk(OFS_COUNT_HIGH, 8'hFF, RESP_OKAY);
    rdchk(OFS_ALT_LOW, 8'hFC, RESP_OKAY);
    rdchk(OFS_ALT_HIGH, 8'hFF, RESP_OKAY);
    rdchk(OFS_CTRL_TWO, 8'h00, RESP_OKAY);
    rdchk(OFS_STATUS, 8'h00, RESP_OKAY);
    rdchk(8'h1C, 8'h00, RESP_SLVERR);
    wrchk(8'h1C, 32'h000000FF, RESP_SLVERR);
    wrchk(OFS_COUNT_HIGH, 32'h00000012, RESP_OKAY);
    run(4);
    chk("count", 32'h0000FFFE, {16'h0, count});
    rdchk(OFS_ALT_LOW, 8'hFC, RESP_OKAY);
    wrchk(OFS_COUNT_LOW, 32'h00000055, RESP_OKAY);
    chk("count", 32'h0000FFFC, {16'h0, count});
    // Buffered low byte across a wrap
    rdchk(OFS_COUNT_HIGH, 8'hFF, RESP_OKAY);
    run(10);
    chk("count", 32'h00000001, {16'h0, count});
    rdchk(OFS_COUNT_HIGH, 8'h00, RESP_OKAY);
    rdchk(OFS_COUNT_LOW, 8'hFC, RESP_OKAY);
    rdchk(OFS_COUNT_LOW, 8'h01, RESP_OKAY);
    rdchk(OFS_STATUS, 8'h20, RESP_OKAY);
    // Interrupt request gated by enable and mask
    wrchk(OFS_CTRL_ONE, 32'h00000080, RESP_OKAY);
    repeat (3) @(posedge clk);
    chk("irq", 32'h0, {31'h0, irq});
    mask <= 1'b0;
    repeat (3) @(posedge clk);
    chk("irq", 32'h1, {31'h0, irq});
    // Flag survives alternate access, clears after status then low read
    rdchk(OFS_STATUS, 8'h20, RESP_OKAY);
    rdchk(OFS_ALT_LOW, 8'h01, RESP_OKAY);
    rdchk(OFS_STATUS, 8'h20, RESP_OKAY);
    rdchk(OFS_COUNT_LOW, 8'h01, RESP_OKAY);
    rdchk(OFS_STATUS, 8'h00, RESP_OKAY);
    repeat (2) @(posedge clk);
    chk("irq", 32'h0, {31'h0, irq});
    // Internal rates with wait mode on: four ticks per window
    wait_m <= 1'b1;
    for (int k = 0; k < 3; k++) begin
      wrchk(OFS_CTRL_TWO, 32'(k), RESP_OKAY);
      halt <= 1'b0;
      repeat (2 << k) @(posedge clk);
      c0 = count;
      repeat (8 << k) @(posedge clk);
      chk("ticks", 32'h00000004, {16'h0, 16'(count - c0)});
      halt <= 1'b1;
    end
    // External source, rising edges then falling edges
    for (int e = 1; e >= 0; e--) begin
      wrchk(OFS_CTRL_TWO, 32'(3 + 4 * e), RESP_OKAY);
      halt <= 1'b0;
      @(posedge clk);
      c0 = count;
      i_src.toggles(3);
      repeat (6) @(posedge clk);
      chk("ext", 32'h00000002, {16'h0, 16'(count - c0)});
      halt <= 1'b1;
    end
    // Mid-run reset restarts the count and clears control
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    chk("count", 32'h0000FFFC, {16'h0, count});
    rdchk(OFS_CTRL_TWO, 8'h00, RESP_OKAY);
    rdchk(OFS_COUNT_LOW, 8'hFC, RESP_OKAY);
    close_out();
  end
endmodule
